// ===== core/ocp_switch_ctrl.sv
// ocp_switch_ctrl: control logic of a protected high-side output switch with retry.
// Assumes pin inputs are asynchronous, comparators report over-current as a level,
// and software reaches the configuration over a classic Wishbone slave port.
//
// Functional notes
// - Output follows command unless protection forces off.
// - Healthy load: output steady, status released.
// - Trip only after over-current outlasts trip delay.
// - Status goes active with the protective turn-off.
// - Variant picks steady or flashing fault indication.
// - Short over-current peaks are ignored entirely.
// - After recovery time, retry if command high.
// - Short still present at retry: off, new recovery.
// - Retry cycle repeats until short or command ends.
// - Command low aborts recovery; next rise retries.
// - Default recovery 500 ms or 20 ms by variant.
// - Sense strapped to ground selects internal switch.
// - Internal mode: switch comparator is over-current.
// - Shunt on sense: output sinks external transistor.
// - External mode: shunt comparator is over-current.
// - Eight trip delays 5 to 1000 us, variant default.
// - Flashing fault toggles near 1.7 Hz, half duty.
`include "ocp_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module ocp_switch_ctrl #(
  parameter bit FLASH_VARIANT = 1'b0,
  parameter bit LONG_DEFAULTS = 1'b1,
  parameter int unsigned CYC_PER_US = `OCP_CYC_PER_US,
  parameter int unsigned US_PER_MS = `OCP_US_PER_MS
) (
  input wire logic REF_CLK,
  input wire logic NRST,
  input wire logic CMD_IN,
  input wire logic SENS_GND_IN,
  input wire logic OC_INT_IN,
  input wire logic OC_EXT_IN,
  output logic OUT_SRC_EN,
  output logic OUT_SINK_EN,
  output logic STATUS_O,
  output logic STATUS_OE,
  input wire ocp_pkg::ocp_adr_t WB_ADR_I,
  input wire ocp_pkg::ocp_data_t WB_DAT_I,
  input wire ocp_pkg::ocp_sel_t WB_SEL_I,
  input wire logic WB_WE_I,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  output ocp_pkg::ocp_data_t WB_DAT_O,
  output logic WB_ACK_O
);
  import ocp_pkg::*;

  // ============================================================
  // Pin synchronisation and mode strap

  // Synchronised pin levels.
  logic cmd_s;
  logic sens_gnd_s;
  logic oc_int_s;
  logic oc_ext_s;
  // Cycles waited after reset before the strap is trusted.
  logic [1:0] strap_wait;
  // Set once the strap has been captured.
  logic strap_done;
  // High when an external power transistor is driven.
  logic ext_mode;

  // All four pins come from outside the clock domain.
  ocp_sync #(
    .W(4)
  ) u_sync (
    .clk(REF_CLK),
    .rst_n(NRST),
    .d({CMD_IN, SENS_GND_IN, OC_INT_IN, OC_EXT_IN}),
    .q({cmd_s, sens_gnd_s, oc_int_s, oc_ext_s})
  );

  assign strap_done = (strap_wait == 2'h3);

  // The strap is caught once, after the synchroniser has filled past reset.
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      strap_wait <= 2'h0;
      ext_mode <= 1'b0;
    end else if (!strap_done) begin
      strap_wait <= strap_wait + 2'h1;
      if (strap_wait == 2'h2) begin
        ext_mode <= !sens_gnd_s;
      end
    end
  end

  // Over-current source depends on the mode.
  logic oc;
  assign oc = ext_mode ? oc_ext_s : oc_int_s;

  // ============================================================
  // Time base: microsecond and millisecond enable pulses

  // Clock cycles within the current microsecond.
  logic [7:0] us_div;
  // Microseconds within the current millisecond.
  logic [9:0] ms_div;
  // One-cycle pulse every microsecond.
  logic us_tick;
  // One-cycle pulse every millisecond.
  logic ms_tick;
  // Divider wrap points.
  logic us_wrap;
  logic ms_wrap;

  assign us_wrap = (us_div == 8'(CYC_PER_US - 1));
  assign ms_wrap = (ms_div == 10'(US_PER_MS - 1));

  // All delays are counted from the reference clock.
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      us_div <= 8'h00;
      ms_div <= 10'h000;
      us_tick <= 1'b0;
      ms_tick <= 1'b0;
    end else begin
      us_div <= us_wrap ? 8'h00 : us_div + 8'h01;
      us_tick <= us_wrap;
      ms_tick <= us_wrap && ms_wrap;
      if (us_wrap) begin
        ms_div <= ms_wrap ? 10'h000 : ms_div + 10'h001;
      end
    end
  end

  // ============================================================
  // Configuration and delay lookup

  // Trip delay code and recovery time code.
  logic [2:0] trip_code;
  logic [2:0] rec_code;
  // Selected delays in microseconds and milliseconds.
  logic [10:0] trip_us;
  logic [10:0] rec_ms;

  // Map the trip code to its delay.
  always_comb begin
    case (trip_code)
      3'h0: trip_us = `OCP_TRIP_US_0;
      3'h1: trip_us = `OCP_TRIP_US_1;
      3'h2: trip_us = `OCP_TRIP_US_2;
      3'h3: trip_us = `OCP_TRIP_US_3;
      3'h4: trip_us = `OCP_TRIP_US_4;
      3'h5: trip_us = `OCP_TRIP_US_5;
      3'h6: trip_us = `OCP_TRIP_US_6;
      default: trip_us = `OCP_TRIP_US_7;
    endcase
  end

  // Map the recovery code to its time.
  always_comb begin
    case (rec_code)
      3'h0: rec_ms = `OCP_REC_MS_0;
      3'h1: rec_ms = `OCP_REC_MS_1;
      3'h2: rec_ms = `OCP_REC_MS_2;
      3'h3: rec_ms = `OCP_REC_MS_3;
      3'h4: rec_ms = `OCP_REC_MS_4;
      3'h5: rec_ms = `OCP_REC_MS_5;
      3'h6: rec_ms = `OCP_REC_MS_6;
      default: rec_ms = `OCP_REC_MS_7;
    endcase
  end

  // Recovery in ms at least trip in us means the thousandfold margin holds.
  logic recovery_to_trip_ratio;
  assign recovery_to_trip_ratio = (rec_ms >= trip_us);

  // ============================================================
  // Protection timers

  // Current state and next state.
  ocp_state_t state;
  ocp_state_t next_state;
  // Timer flags.
  logic trip_expired;
  logic rec_expired;
  logic flash_expired;
  // Fault indication and flash phase.
  logic fault;
  logic flash_phase;

  // One tick beyond the delay guarantees the over-current lasted longer than it.
  ocp_timer #(
    .W(11)
  ) u_trip (
    .clk(REF_CLK),
    .rst_n(NRST),
    .clear(!((state == OCP_ON) && oc)),
    .tick(us_tick),
    .limit(trip_us + 11'h001),
    .expired(trip_expired)
  );

  // Recovery wait runs only while the output is held off by a fault.
  ocp_timer #(
    .W(11)
  ) u_rec (
    .clk(REF_CLK),
    .rst_n(NRST),
    .clear(state != OCP_FAULT),
    .tick(ms_tick),
    .limit(rec_ms + 11'h001),
    .expired(rec_expired)
  );

  // Half period of the flashing indication.
  ocp_timer #(
    .W(11)
  ) u_flash (
    .clk(REF_CLK),
    .rst_n(NRST),
    .clear(!fault || flash_expired),
    .tick(ms_tick),
    .limit(11'(`OCP_FLASH_HALF_MS)),
    .expired(flash_expired)
  );

  // ============================================================
  // Switch state machine

  // Decide the next state from command, trip and recovery.
  always_comb begin
    next_state = state;
    case (state)
      OCP_IDLE: begin
        // Start-up has settled once the strap is caught.
        if (cmd_s && strap_done) begin
          next_state = OCP_ON;
        end
      end
      OCP_ON: begin
        if (!cmd_s) begin
          next_state = OCP_IDLE;
        end else if (trip_expired) begin
          next_state = OCP_FAULT;
        end
      end
      OCP_FAULT: begin
        if (!cmd_s) begin
          next_state = OCP_IDLE;
        end else if (rec_expired) begin
          next_state = OCP_ON;
        end
      end
      default: begin
        next_state = OCP_IDLE;
      end
    endcase
  end

  // Fault indication follows the state machine in the same cycle. It stays
  // active across a retry while the short persists, and clears at the first
  // microsecond tick that finds the output on with no over-current.
  logic next_fault;
  logic next_phase;
  logic next_on;
  assign next_on = (next_state == OCP_ON);
  assign next_fault = (next_state == OCP_FAULT) ||
                      (fault && (next_state == OCP_ON) && !(!oc && us_tick));
  assign next_phase = !next_fault || !fault || (flash_expired ? !flash_phase : flash_phase);

  // State, fault flag and flash phase.
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      state <= OCP_IDLE;
      fault <= 1'b0;
      flash_phase <= 1'b1;
    end else begin
      state <= next_state;
      fault <= next_fault;
      flash_phase <= next_phase;
    end
  end

  // Pin drivers change together with the state; status pulls low when active.
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      OUT_SRC_EN <= 1'b0;
      OUT_SINK_EN <= 1'b0;
      STATUS_O <= 1'b0;
      STATUS_OE <= 1'b0;
    end else begin
      OUT_SRC_EN <= next_on && !ext_mode;
      OUT_SINK_EN <= next_on && ext_mode;
      STATUS_O <= 1'b0;
      STATUS_OE <= next_fault && (!FLASH_VARIANT || next_phase);
    end
  end

  // ============================================================
  // Wishbone slave

  // Request present, write strobes and read data.
  logic wb_req;
  logic wr_ctrl;
  logic wr_trips;
  logic next_ack;
  ocp_data_t rd_data;
  ocp_data_t ctrl_word;
  ocp_data_t stat_word;
  // Count of protective turn-offs.
  logic [15:0] trips;
  logic trip_event;

  assign wb_req = WB_CYC_I && WB_STB_I;
  assign next_ack = wb_req && !WB_ACK_O;
  assign wr_ctrl = wb_req && WB_WE_I && WB_ACK_O && (WB_ADR_I == `OCP_REG_CTRL) && WB_SEL_I[0];
  assign wr_trips = wb_req && WB_WE_I && WB_ACK_O && (WB_ADR_I == `OCP_REG_TRIPS) && (WB_SEL_I != 4'h0);
  assign trip_event = (state == OCP_ON) && (next_state == OCP_FAULT);

  assign ctrl_word = {25'h000_0000, rec_code, 1'b0, trip_code};
  assign stat_word = {21'h00_0000, state, 2'h0, recovery_to_trip_ratio, oc, cmd_s, ext_mode, fault,
                      (state == OCP_ON)};
  assign rd_data = (WB_ADR_I == `OCP_REG_CTRL) ? ctrl_word :
                   (WB_ADR_I == `OCP_REG_STAT) ? stat_word :
                   (WB_ADR_I == `OCP_REG_TRIPS) ? {16'h0000, trips} : 32'h0000_0000;

  // Acknowledge one cycle after the request; unmapped words read zero.
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end else begin
      WB_ACK_O <= next_ack;
      WB_DAT_O <= next_ack ? rd_data : 32'h0000_0000;
    end
  end

  // Delay codes take their variant defaults at reset and may change at any time.
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      trip_code <= LONG_DEFAULTS ? `OCP_TRIP_DEF_LONG : `OCP_TRIP_DEF_SHORT;
      rec_code <= LONG_DEFAULTS ? `OCP_REC_DEF_LONG : `OCP_REC_DEF_SHORT;
    end else if (wr_ctrl) begin
      trip_code <= WB_DAT_I[`OCP_CTRL_TRIP_LSB +: 3];
      rec_code <= WB_DAT_I[`OCP_CTRL_REC_LSB +: 3];
    end
  end

  // A trip in the clearing cycle is still counted; the count stops at its top.
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      trips <= 16'h0000;
    end else if (trip_event) begin
      if (wr_trips) begin
        trips <= 16'h0001;
      end else if (trips != 16'hFFFF) begin
        trips <= trips + 16'h0001;
      end
    end else if (wr_trips) begin
      trips <= 16'h0000;
    end
  end
endmodule : ocp_switch_ctrl
`default_nettype wire

// ===== inc/ocp_defs.svh
// ocp_defs.svh: register offsets, field positions, reset codes and timing counts of the
// over-current protected output switch.
// Assumes a 200 MHz reference clock and a 32-bit classic Wishbone register bus.
`ifndef OCP_DEFS_SVH
`define OCP_DEFS_SVH

// ============================================================
// Register map (byte addresses, one aligned word each)
`define OCP_REG_CTRL 4'h0
`define OCP_REG_STAT 4'h4
`define OCP_REG_TRIPS 4'h8

// ============================================================
// Field positions
`define OCP_CTRL_TRIP_LSB 0
`define OCP_CTRL_REC_LSB 4
`define OCP_STAT_ON 0
`define OCP_STAT_FAULT 1
`define OCP_STAT_EXT 2
`define OCP_STAT_CMD 3
`define OCP_STAT_OC 4
`define OCP_STAT_RATIO 5
`define OCP_STAT_STATE_LSB 8

// ============================================================
// Reset codes of the delay selections per variant
`define OCP_TRIP_DEF_LONG 3'h0
`define OCP_TRIP_DEF_SHORT 3'h4
`define OCP_REC_DEF_LONG 3'h5
`define OCP_REC_DEF_SHORT 3'h1

// ============================================================
// Timing: clock period, trip delays in us, recovery times in ms
`define OCP_CLK_PERIOD_NS 5
`define OCP_NS_PER_US 1000
`define OCP_CYC_PER_US (`OCP_NS_PER_US / `OCP_CLK_PERIOD_NS)
`define OCP_US_PER_MS 1000
`define OCP_FLASH_FREQ_CHZ 170
`define OCP_FLASH_HALF_MS (100000 / (2 * `OCP_FLASH_FREQ_CHZ))
`define OCP_TRIP_US_0 11'h032
`define OCP_TRIP_US_1 11'h005
`define OCP_TRIP_US_2 11'h00A
`define OCP_TRIP_US_3 11'h014
`define OCP_TRIP_US_4 11'h064
`define OCP_TRIP_US_5 11'h0C8
`define OCP_TRIP_US_6 11'h1F4
`define OCP_TRIP_US_7 11'h3E8
`define OCP_REC_MS_0 11'h00A
`define OCP_REC_MS_1 11'h014
`define OCP_REC_MS_2 11'h032
`define OCP_REC_MS_3 11'h064
`define OCP_REC_MS_4 11'h0C8
`define OCP_REC_MS_5 11'h1F4
`define OCP_REC_MS_6 11'h3E8
`define OCP_REC_MS_7 11'h5DC

`endif

// ===== inc/ocp_pkg.sv
// ocp_pkg: types shared by the over-current protected output switch.
// Assumes nothing beyond a SystemVerilog compiler.
package ocp_pkg;
  // Wishbone address, data and byte-select types.
  typedef logic [3:0] ocp_adr_t;
  typedef logic [31:0] ocp_data_t;
  typedef logic [3:0] ocp_sel_t;
  // Switch controller states, one-hot.
  typedef enum logic [2:0] {
    OCP_IDLE = 3'h1,
    OCP_ON = 3'h2,
    OCP_FAULT = 3'h4
  } ocp_state_t;
endpackage : ocp_pkg

// ===== core/ocp_sync.sv
// ocp_sync: two flip-flop synchroniser for a group of asynchronous pin levels.
// Assumes each bit is an independent level held far longer than a clock period.
`timescale 1ns/1ps
`default_nettype none
module ocp_sync #(
  parameter int unsigned W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  // First stage; read only by the second stage.
  logic [W-1:0] meta;

  // Two stages clear the metastable window before any logic looks at the level.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : ocp_sync
`default_nettype wire

// ===== core/ocp_timer.sv
// ocp_timer: saturating tick counter with a registered limit-reached flag.
// Assumes tick is a one-cycle enable pulse on the same clock.
`timescale 1ns/1ps
`default_nettype none
module ocp_timer #(
  parameter int unsigned W = 11
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic tick,
  input wire logic [W-1:0] limit,
  output logic expired
);
  // Ticks seen since the last clear.
  logic [W-1:0] cnt;
  // Count value for the next cycle.
  logic [W-1:0] next_cnt;

  // Clear wins; otherwise count ticks and stop at the top to avoid wrapping.
  always_comb begin
    if (clear) begin
      next_cnt = '0;
    end else if (tick && (cnt != {W{1'b1}})) begin
      next_cnt = cnt + {{(W-1){1'b0}}, 1'b1};
    end else begin
      next_cnt = cnt;
    end
  end

  // The flag goes high in the same cycle that the count reaches the limit.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
      expired <= 1'b0;
    end else begin
      cnt <= next_cnt;
      expired <= !clear && (next_cnt >= limit);
    end
  end
endmodule : ocp_timer
`default_nettype wire

// ===== sim/ocp_switch_ctrl_sva.sv
// Port-level checker of the protected switch controller.
// Assumes it is bound to every ocp_switch_ctrl instance and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module ocp_switch_ctrl_sva
  import ocp_pkg::*;
#(
  parameter bit FLASH_VARIANT = 1'b0,
  parameter int unsigned CYC_PER_US = 200
) (
  input wire logic REF_CLK,
  input wire logic NRST,
  input wire logic CMD_IN,
  input wire logic OC_INT_IN,
  input wire logic OC_EXT_IN,
  input wire logic OUT_SRC_EN,
  input wire logic OUT_SINK_EN,
  input wire logic STATUS_O,
  input wire logic STATUS_OE,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire ocp_pkg::ocp_data_t WB_DAT_O,
  input wire logic WB_ACK_O
);
  // ==========================================================
  // Helper counters of over-current and healthy on time.
  logic [15:0] oc_cnt; // Consecutive cycles with over-current.
  logic [15:0] ok_cnt; // Consecutive cycles driven on without over-current.
  logic [15:0] next_oc_cnt;
  logic [15:0] next_ok_cnt;
  wire logic drv_on; // Either output driver is on.
  assign drv_on = OUT_SRC_EN | OUT_SINK_EN;
  assign next_oc_cnt = !(OC_INT_IN | OC_EXT_IN) ? 16'h0000 : (oc_cnt == 16'hFFFF) ? oc_cnt : oc_cnt + 16'h0001;
  assign next_ok_cnt = !(drv_on & !OC_INT_IN & !OC_EXT_IN) ? 16'h0000 :
                       (ok_cnt == 16'hFFFF) ? ok_cnt : ok_cnt + 16'h0001;
  // The counters restart with every reset.
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      oc_cnt <= 16'h0000;
      ok_cnt <= 16'h0000;
    end else begin
      oc_cnt <= next_oc_cnt;
      ok_cnt <= next_ok_cnt;
    end
  end
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!NRST);
  // ==========================================================
  // Properties.
  property p_cmd_off; $fell(CMD_IN) |-> ##[1:4] !drv_on; endproperty
  property p_rise_cmd; $rose(drv_on) |-> CMD_IN; endproperty
  property p_one_drv; !(OUT_SRC_EN && OUT_SINK_EN); endproperty
  property p_trip_status; !FLASH_VARIANT && $rose(STATUS_OE) |-> $fell(drv_on); endproperty
  property p_trip_min; !FLASH_VARIANT && $rose(STATUS_OE) |-> oc_cnt >= 5 * CYC_PER_US; endproperty
  property p_healthy; ok_cnt > CYC_PER_US + 4 |-> !STATUS_OE; endproperty
  property p_status_lvl; STATUS_O == 1'b0; endproperty
  property p_ack; WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O; endproperty
  property p_ack_one; WB_ACK_O |=> !WB_ACK_O; endproperty
  property p_dat_zero; !WB_ACK_O |-> WB_DAT_O == 32'h0000_0000; endproperty
  a_cmd_off: assert property (p_cmd_off) else $error("output still on after command low");
  a_rise_cmd: assert property (p_rise_cmd) else $error("output rose without command");
  a_one_drv: assert property (p_one_drv) else $error("both drivers on");
  a_trip_status: assert property (p_trip_status) else $error("status without turn-off");
  a_trip_min: assert property (p_trip_min) else $error("trip before shortest delay");
  a_healthy: assert property (p_healthy) else $error("status held on healthy load");
  a_status_lvl: assert property (p_status_lvl) else $error("status drives high");
  a_ack: assert property (p_ack) else $error("no ack one cycle after request");
  a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
  a_dat_zero: assert property (p_dat_zero) else $error("read data outside ack");
  c_trip: cover property ($rose(STATUS_OE));
  c_retry: cover property (STATUS_OE && $rose(drv_on));
  c_ack: cover property (WB_ACK_O);
endmodule : ocp_switch_ctrl_sva
bind ocp_switch_ctrl ocp_switch_ctrl_sva #(.FLASH_VARIANT(FLASH_VARIANT), .CYC_PER_US(CYC_PER_US)) sva_i (
  .REF_CLK(REF_CLK), .NRST(NRST), .CMD_IN(CMD_IN), .OC_INT_IN(OC_INT_IN), .OC_EXT_IN(OC_EXT_IN),
  .OUT_SRC_EN(OUT_SRC_EN), .OUT_SINK_EN(OUT_SINK_EN), .STATUS_O(STATUS_O), .STATUS_OE(STATUS_OE),
  .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O));
`default_nettype wire

// ===== sim/ocp_ctrl_model.sv
// Model of the controller and load beside the switch.
// Assumes a pulled-up status line and a load that draws current only while driven.
`timescale 1ns/1ps
`default_nettype none
module ocp_ctrl_model #(
  parameter int unsigned STARTUP_CYC = 16
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic go,
  input wire logic short_req,
  input wire logic src_en,
  input wire logic sink_en,
  input wire logic status_o,
  input wire logic status_oe,
  output logic cmd,
  output logic oc_int,
  output logic oc_ext,
  output logic fault_seen
);
  // ==========================================================
  // Command pin, held low through start-up.
  logic [7:0] start_cnt; // Cycles since power-up.
  wire logic start_done; // Start-up interval over.
  assign start_done = (start_cnt == 8'(STARTUP_CYC));
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      start_cnt <= 8'h00;
      cmd <= 1'b0;
    end else begin
      start_cnt <= start_done ? start_cnt : start_cnt + 8'h01;
      cmd <= go & start_done;
    end
  end
  // A short draws current only through the driver that is on.
  assign oc_int = short_req & src_en;
  assign oc_ext = short_req & sink_en;
  // Pulled-up open-drain line: low means fault.
  assign fault_seen = status_oe & !status_o;
endmodule : ocp_ctrl_model
`default_nettype wire

// ===== sim/ocp_switch_ctrl_tb.sv
// Self-checking bench of the protected switch controller.
// Assumes 4 clocks a microsecond and 4 microseconds a millisecond.
`include "ocp_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module ocp_switch_ctrl_tb;
  import ocp_pkg::*;
  // ==========================================================
  // Pins, bus and counters.
  logic ref_clk, nrst, go, short_req, sens, cmd, oc_int, oc_ext, fault_seen;
  logic src, sink, st_o, st_oe, src2, sink2, st_o2, st_oe2, we, cyc, stb, ack;
  ocp_adr_t adr;
  ocp_data_t wdat, rdat, q;
  ocp_sel_t sel;
  int err_total, tests_run, n, cyc_cnt;
  wire logic drv_on;
  assign drv_on = src | sink;
  ocp_ctrl_model ocp_ctrl_model_i (.clk(ref_clk), .nrst(nrst), .go(go), .short_req(short_req),
    .src_en(src), .sink_en(sink), .status_o(st_o), .status_oe(st_oe), .cmd(cmd),
    .oc_int(oc_int), .oc_ext(oc_ext), .fault_seen(fault_seen));
  ocp_switch_ctrl #(.CYC_PER_US(4), .US_PER_MS(4)) ocp_switch_ctrl_i (.REF_CLK(ref_clk), .NRST(nrst),
    .CMD_IN(cmd), .SENS_GND_IN(sens), .OC_INT_IN(oc_int), .OC_EXT_IN(oc_ext), .OUT_SRC_EN(src),
    .OUT_SINK_EN(sink), .STATUS_O(st_o), .STATUS_OE(st_oe), .WB_ADR_I(adr), .WB_DAT_I(wdat),
    .WB_SEL_I(sel), .WB_WE_I(we), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_DAT_O(rdat), .WB_ACK_O(ack));
  // Flashing variant shares command, strap and bus; its status and drivers are watched.
  ocp_switch_ctrl #(.FLASH_VARIANT(1'b1), .CYC_PER_US(4), .US_PER_MS(4)) ocp_switch_ctrl_f_i (
    .REF_CLK(ref_clk), .NRST(nrst), .CMD_IN(cmd), .SENS_GND_IN(sens), .OC_INT_IN(short_req & src2),
    .OC_EXT_IN(short_req & sink2), .OUT_SRC_EN(src2), .OUT_SINK_EN(sink2), .STATUS_O(st_o2), .STATUS_OE(st_oe2),
    .WB_ADR_I(adr), .WB_DAT_I(wdat), .WB_SEL_I(sel), .WB_WE_I(we), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_DAT_O(), .WB_ACK_O());
  // ==========================================================
  // Tasks.
  task automatic print_verdict();
    $display("TB: errors=%0d checks=%0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict
  // Compares two values and reports a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask : chk
  // Checks that the last measured wait lies within bounds.
  task automatic rng(input int lo, input int hi);
    chk(32'(n >= lo && n <= hi), 32'h0000_0001);
  endtask : rng
  // One classic Wishbone cycle; read data lands in q.
  task automatic xfer(input ocp_adr_t a, input logic w, input ocp_data_t d);
    int k;
    k = 0;
    @(posedge ref_clk);
    adr <= a;
    we <= w;
    wdat <= d;
    sel <= 4'hF;
    cyc <= 1'b1;
    stb <= 1'b1;
    do begin
      @(posedge ref_clk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    chk(32'(k < 20), 32'h0000_0001);
  endtask : xfer
  // Waits a bounded number of cycles for the output to reach a level.
  task automatic wait_on(input logic lvl, input int maxc);
    n = 0;
    while (drv_on !== lvl && n < maxc) begin
      @(posedge ref_clk);
      n++;
    end
  endtask : wait_on
  // Reset held four cycles with the strap given.
  task automatic rst(input logic s);
    @(posedge ref_clk);
    nrst <= 1'b0;
    sens <= s;
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
  endtask : rst
  // ==========================================================
  // Clock and hang guard.
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  initial begin
    cyc_cnt = 0;
    forever begin
      @(posedge ref_clk);
      cyc_cnt++;
      if (cyc_cnt == 40000) begin
        err_total++;
        print_verdict();
      end
    end
  end
  // ==========================================================
  // Main sequence.
  initial begin
    {nrst, go, short_req, we, cyc, stb} = 6'h00;
    sens = 1'b1;
    adr = 4'h0;
    wdat = 32'h0000_0000;
    sel = 4'h0;
    err_total = 0;
    tests_run = 0;
    rst(1'b1);
    xfer(`OCP_REG_CTRL, 1'b0, 32'h0000_0000);
    chk(q, 32'h0000_0050);
    xfer(`OCP_REG_STAT, 1'b0, 32'h0000_0000);
    chk(q, 32'h0000_0120);
    xfer(4'hC, 1'b0, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    xfer(`OCP_REG_CTRL, 1'b1, 32'h0000_0001);
    xfer(`OCP_REG_CTRL, 1'b0, 32'h0000_0000);
    chk(q, 32'h0000_0001);
    go <= 1'b1;
    wait_on(1'b1, 60);
    chk(32'({src, sink, fault_seen}), 32'h0000_0004);
    short_req <= 1'b1;
    repeat (15) @(posedge ref_clk);
    short_req <= 1'b0;
    @(posedge ref_clk);
    short_req <= 1'b1;
    repeat (15) @(posedge ref_clk);
    short_req <= 1'b0;
    repeat (40) @(posedge ref_clk);
    chk(32'({src, fault_seen}), 32'h0000_0002);
    short_req <= 1'b1;
    wait_on(1'b0, 100);
    rng(20, 32);
    chk(32'(fault_seen), 32'h0000_0001);
    wait_on(1'b1, 400);
    rng(160, 190);
    chk(32'(fault_seen), 32'h0000_0001);
    wait_on(1'b0, 100);
    rng(20, 32);
    wait_on(1'b1, 400);
    short_req <= 1'b0;
    rng(160, 190);
    repeat (12) @(posedge ref_clk);
    chk(32'({src, fault_seen}), 32'h0000_0002);
    short_req <= 1'b1;
    wait_on(1'b0, 100);
    go <= 1'b0;
    repeat (8) @(posedge ref_clk);
    chk(32'({drv_on, st_oe}), 32'h0000_0000);
    go <= 1'b1;
    wait_on(1'b1, 20);
    short_req <= 1'b0;
    rng(0, 8);
    xfer(`OCP_REG_TRIPS, 1'b0, 32'h0000_0000);
    chk(q, 32'h0000_0003);
    xfer(`OCP_REG_TRIPS, 1'b1, 32'h0000_0000);
    xfer(`OCP_REG_TRIPS, 1'b0, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    short_req <= 1'b1;
    n = 0;
    while (st_oe2 !== 1'b1 && n < 100) begin
      @(posedge ref_clk);
      n++;
    end
    n = 0;
    while (st_oe2 === 1'b1 && n < 6000) begin
      @(posedge ref_clk);
      n++;
    end
    rng(4688, 4736);
    short_req <= 1'b0;
    go <= 1'b0;
    rst(1'b0);
    go <= 1'b1;
    wait_on(1'b1, 60);
    chk(32'({src, sink, src2, sink2, st_o2}), 32'h0000_000A);
    short_req <= 1'b1;
    wait_on(1'b0, 300);
    rng(200, 212);
    wait_on(1'b1, 9000);
    rng(8000, 8025);
    print_verdict();
  end
endmodule : ocp_switch_ctrl_tb
`default_nettype wire
